// ---- verilog/cadp_pkg.sv ----
// Constants, modes and bus bundles for the core address decode and paging block
package cadp_pkg;
    // ****************************************************
    // Register indices (byte address is four times these)
    // ****************************************************
    localparam logic [7:0] CADP_IDX_VIEW = 8'h1D;
    localparam logic [7:0] CADP_IDX_PAGE = 8'h30;
    localparam logic [7:0] CADP_IDX_CTRL = 8'h10;
    localparam logic [7:0] CADP_IDX_BASE = 8'h11;

    // ****************************************************
    // Field positions and reset values
    // ****************************************************
    localparam int CADP_VIEW_ROM_LSB = 6;
    localparam int CADP_VIEW_PAG_LSB = 0;
    localparam int CADP_CTRL_ROM_ON = 0;
    localparam int CADP_CTRL_UPPER = 1;
    localparam int CADP_CTRL_EE_ON = 2;
    localparam int CADP_CTRL_PE_EXT = 3;
    localparam int CADP_CTRL_PK_EXT = 4;
    localparam logic [4:0] CADP_CTRL_RESET = 5'h01;
    localparam int CADP_BASE_REG_LSB = 0;
    localparam int CADP_BASE_RAM_LSB = 8;
    localparam int CADP_BASE_EE_LSB = 16;
    localparam logic [5:0] CADP_REG_BASE_RESET = 6'h00;
    localparam logic [3:0] CADP_RAM_BASE_RESET = 4'h3;
    localparam logic [4:0] CADP_EE_BASE_RESET = 5'h01;
    localparam logic [5:0] CADP_PAGE_RESET_ANY = 6'h00;
    localparam logic [5:0] CADP_PAGE_RESET_SPECIAL = 6'h3C;

    // ****************************************************
    // Address map figures
    // ****************************************************
    localparam logic [1:0] CADP_WINDOW_QTR = 2'h2;
    localparam logic [1:0] CADP_TOP_QTR = 2'h3;
    localparam logic [1:0] CADP_LOW_QTR = 2'h0;
    localparam logic [7:0] CADP_DEBUG_PAGE = 8'hFF;
    localparam logic [5:0] CADP_PAGE_INT_00 = 6'h38;
    localparam logic [5:0] CADP_PAGE_INT_01 = 6'h30;
    localparam logic [5:0] CADP_PAGE_INT_10 = 6'h20;
    localparam logic [5:0] CADP_PAGE_INT_11 = 6'h00;
    localparam logic [9:0] CADP_OFF_PORTA = 10'h000;
    localparam logic [9:0] CADP_OFF_PORTB = 10'h001;
    localparam logic [9:0] CADP_OFF_DDRA = 10'h002;
    localparam logic [9:0] CADP_OFF_DDRB = 10'h003;
    localparam logic [9:0] CADP_OFF_PORTE = 10'h008;
    localparam logic [9:0] CADP_OFF_DDRE = 10'h009;
    localparam logic [9:0] CADP_OFF_PORTK = 10'h032;
    localparam logic [9:0] CADP_OFF_DDRK = 10'h033;
    localparam logic [9:0] CADP_OFF_PERIPH_END = 10'h010;

    // ****************************************************
    // Types
    // ****************************************************
    typedef enum logic [2:0] {
        CADP_MODE_SPEC_SINGLE = 3'h0,
        CADP_MODE_EMUL_NARROW = 3'h1,
        CADP_MODE_SPEC_TEST = 3'h2,
        CADP_MODE_EMUL_WIDE = 3'h3,
        CADP_MODE_NORM_SINGLE = 3'h4,
        CADP_MODE_NORM_NARROW = 3'h5,
        CADP_MODE_SPEC_PERIPH = 3'h6,
        CADP_MODE_NORM_WIDE = 3'h7
    } cadp_mode_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic wide;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cadp_req_t;

    typedef struct packed {
        logic debug;
        logic regs;
        logic ram;
        logic eeprom;
        logic flash;
        logic ext;
    } cadp_sel_t;

    typedef struct packed {
        logic [15:0] debug;
        logic [15:0] regs;
        logic [15:0] ram;
        logic [15:0] eeprom;
        logic [15:0] flash;
        logic [15:0] ext;
    } cadp_rdata_t;

    typedef struct packed {
        logic write;
        logic wide;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [5:0] page;
    } cadp_bus_t;
endpackage

// ---- verilog/cadp_core.sv ----
// Core address decode, select priority, program paging and read data steering
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Size view readable anytime, writes ignored
// - Flash size code: none, 32K, 48K, 64K
// - Paging code: 128K, 256K, 512K, 1M on-chip
// - Six page bits map 16K into 0x8000-0xBFFF
// - Page number is binary value 0-63
// - Page reset 0x00 any-mode or 0x3C special-only
// - Bus write next cycle; far write before end
// - Dedicated far path bypasses address bus
// - Mux read buses, steer outputs, swap bytes
// - Decode uses mode and mapping control registers
// - At most one select per access
// - Priority debug, regs, removed regs to external, RAM, EEPROM, flash, external
// - Overlap: only highest select, lower hidden
// - Expansion windows lowest priority
// - Two active-low chip selects: emulation, external
// - Expanded: unclaimed external, ports A/B removed
// - Port-E enable removes port E registers in expanded modes
// - Special peripheral removes first 16 registers
// - Emulation with port-K enable removes port K
// - Upper-half-only blocks lower fixed flash pages
// - External select only without emulation select
// - Window internal/external from page and partition
module cadp_core #(
    parameter bit PAGE_SPECIAL_ONLY = 1'b0
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [1:0] flash_size_switch_i,
    input wire logic [1:0] paging_partition_switch_i,
    input wire cadp_pkg::cadp_mode_t mode_i,
    input wire logic background_debug_i,
    input wire cadp_pkg::cadp_req_t cpu_req_i,
    input wire cadp_pkg::cadp_rdata_t core_rdata_i,
    output logic [15:0] cpu_rdata_o,
    output cadp_pkg::cadp_bus_t core_bus_o,
    output cadp_pkg::cadp_sel_t core_sel_o,
    output logic emulation_chip_select_n_o,
    output logic external_chip_select_n_o,
    input wire logic far_wr_i,
    input wire logic [5:0] far_wdata_i,
    output logic [5:0] far_rdata_o
);
    import cadp_pkg::*;

    // ****************************************************
    // Mode helpers
    // ****************************************************
    function automatic logic is_special(input cadp_mode_t m);
        return (m[2] == 1'b0) || (m == CADP_MODE_SPEC_PERIPH);
    endfunction

    function automatic logic is_emulation(input cadp_mode_t m);
        return (m == CADP_MODE_EMUL_NARROW) || (m == CADP_MODE_EMUL_WIDE);
    endfunction

    function automatic logic is_expanded(input cadp_mode_t m);
        return (m != CADP_MODE_SPEC_SINGLE) && (m != CADP_MODE_NORM_SINGLE)
            && (m != CADP_MODE_SPEC_PERIPH);
    endfunction

    // Window page on-chip when at or above the partition threshold
    function automatic logic page_internal(input logic [5:0] pg, input logic [1:0] sw);
        logic [5:0] lim;
        unique case (sw)
            2'b00: lim = CADP_PAGE_INT_00;
            2'b01: lim = CADP_PAGE_INT_01;
            2'b10: lim = CADP_PAGE_INT_10;
            2'b11: lim = CADP_PAGE_INT_11;
        endcase
        return pg >= lim;
    endfunction

    // ****************************************************
    // Registers
    // ****************************************************
    logic [5:0] page;
    logic [4:0] ctrl;
    logic [5:0] reg_base;
    logic [3:0] ram_base;
    logic [4:0] ee_base;
    logic ahb_wr_q;
    logic [7:0] ahb_idx_q;
    logic [7:0] view;

    wire logic ahb_take = hsel_i && htrans_i[1] && hready_i;
    wire logic [7:0] ahb_idx = haddr_i[9:2];
    wire logic page_wr_ok = !PAGE_SPECIAL_ONLY || is_special(mode_i);
    wire logic page_bus_wr = ahb_wr_q && (ahb_idx_q == CADP_IDX_PAGE) && page_wr_ok;

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign far_rdata_o = page;

    // Switches read straight through, unused bits zero
    always_comb begin
        view = 8'h00;
        view[CADP_VIEW_ROM_LSB +: 2] = flash_size_switch_i;
        view[CADP_VIEW_PAG_LSB +: 2] = paging_partition_switch_i;
    end

    // Data phase bookkeeping for zero-wait transfers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ahb_wr_q <= 1'b0;
            ahb_idx_q <= 8'h00;
        end else if (hready_i) begin
            ahb_wr_q <= ahb_take && hwrite_i;
            ahb_idx_q <= ahb_idx;
        end
    end

    // Far path wins a same-cycle clash so the instruction finishes on time
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            page <= PAGE_SPECIAL_ONLY ? CADP_PAGE_RESET_SPECIAL : CADP_PAGE_RESET_ANY;
        end else if (far_wr_i) begin
            page <= far_wdata_i;
        end else if (page_bus_wr) begin
            page <= hwdata_i[5:0];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl <= CADP_CTRL_RESET;
        end else if (ahb_wr_q && ahb_idx_q == CADP_IDX_CTRL) begin
            ctrl <= hwdata_i[4:0];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_base <= CADP_REG_BASE_RESET;
            ram_base <= CADP_RAM_BASE_RESET;
            ee_base <= CADP_EE_BASE_RESET;
        end else if (ahb_wr_q && ahb_idx_q == CADP_IDX_BASE) begin
            reg_base <= hwdata_i[CADP_BASE_REG_LSB +: 6];
            ram_base <= hwdata_i[CADP_BASE_RAM_LSB +: 4];
            ee_base <= hwdata_i[CADP_BASE_EE_LSB +: 5];
        end
    end

    // Read data launched in the address phase; a write still in its
    // data phase is forwarded so back-to-back write/read sees new data
    logic [31:0] next_hrdata;
    logic fwd;
    always_comb begin
        fwd = ahb_wr_q && (ahb_idx_q == ahb_idx);
        next_hrdata = 32'h0000_0000;
        unique case (ahb_idx)
            CADP_IDX_VIEW: next_hrdata[7:0] = view;
            CADP_IDX_PAGE: begin
                next_hrdata[5:0] = (fwd && page_wr_ok) ? hwdata_i[5:0] : page;
            end
            CADP_IDX_CTRL: next_hrdata[4:0] = fwd ? hwdata_i[4:0] : ctrl;
            CADP_IDX_BASE: begin
                if (fwd) begin
                    next_hrdata[CADP_BASE_REG_LSB +: 6] = hwdata_i[CADP_BASE_REG_LSB +: 6];
                    next_hrdata[CADP_BASE_RAM_LSB +: 4] = hwdata_i[CADP_BASE_RAM_LSB +: 4];
                    next_hrdata[CADP_BASE_EE_LSB +: 5] = hwdata_i[CADP_BASE_EE_LSB +: 5];
                end else begin
                    next_hrdata[CADP_BASE_REG_LSB +: 6] = reg_base;
                    next_hrdata[CADP_BASE_RAM_LSB +: 4] = ram_base;
                    next_hrdata[CADP_BASE_EE_LSB +: 5] = ee_base;
                end
            end
            default: next_hrdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (ahb_take && !hwrite_i) begin
            hrdata_o <= next_hrdata;
        end
    end

    // ****************************************************
    // Address decode
    // ****************************************************
    logic rom_on;
    logic upper_only;
    logic ee_on;
    logic pe_ext;
    logic pk_ext;
    logic [15:0] a;
    logic [9:0] off;
    logic in_reg;
    logic removed;
    logic flash_region;
    logic flash_int;
    logic emu_cs_hit;
    logic ext_cs_hit;
    cadp_sel_t sel;

    always_comb begin
        rom_on = ctrl[CADP_CTRL_ROM_ON];
        upper_only = ctrl[CADP_CTRL_UPPER];
        ee_on = ctrl[CADP_CTRL_EE_ON];
        pe_ext = ctrl[CADP_CTRL_PE_EXT];
        pk_ext = ctrl[CADP_CTRL_PK_EXT];
        a = cpu_req_i.addr;
        off = a[9:0];
        in_reg = (a[15:10] == reg_base);
        removed = 1'b0;
        if (is_expanded(mode_i)) begin
            removed = (off == CADP_OFF_PORTA) || (off == CADP_OFF_PORTB)
                || (off == CADP_OFF_DDRA) || (off == CADP_OFF_DDRB);
            if (pe_ext && (off == CADP_OFF_PORTE || off == CADP_OFF_DDRE)) begin
                removed = 1'b1;
            end
        end
        if (mode_i == CADP_MODE_SPEC_PERIPH && off < CADP_OFF_PERIPH_END) begin
            removed = 1'b1;
        end
        if (is_emulation(mode_i) && pk_ext
            && (off == CADP_OFF_PORTK || off == CADP_OFF_DDRK)) begin
            removed = 1'b1;
        end
        removed = removed && in_reg;
        unique case (a[15:14])
            CADP_TOP_QTR: flash_region = flash_size_switch_i != 2'b00;
            CADP_WINDOW_QTR: flash_region = flash_size_switch_i != 2'b00;
            CADP_LOW_QTR: flash_region = (flash_size_switch_i == 2'b11) && !upper_only;
            default: flash_region = flash_size_switch_i[1] && !upper_only;
        endcase
        // Window hits follow the page against the partition
        flash_int = rom_on && flash_region
            && (a[15:14] != CADP_WINDOW_QTR
                || page_internal(page, paging_partition_switch_i));
        sel = '0;
        // Strict if-else chain keeps the selects one-hot
        if (background_debug_i && a[15:8] == CADP_DEBUG_PAGE) begin
            sel.debug = 1'b1;
        end else if (in_reg && !removed) begin
            sel.regs = 1'b1;
        end else if (removed) begin
            sel.ext = 1'b1;
        end else if (a[15:12] == ram_base) begin
            sel.ram = 1'b1;
        end else if (ee_on && a[15:11] == ee_base) begin
            sel.eeprom = 1'b1;
        end else if (flash_int) begin
            sel.flash = 1'b1;
        end else if (is_expanded(mode_i)) begin
            sel.ext = 1'b1;
        end
        if (!cpu_req_i.valid) begin
            sel = '0;
        end
        emu_cs_hit = is_emulation(mode_i) && pk_ext && sel.flash;
        ext_cs_hit = pk_ext && !emu_cs_hit && sel.ext && !removed;
    end

    // ****************************************************
    // Output steering and read data return
    // ****************************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_sel_o <= '0;
            emulation_chip_select_n_o <= 1'b1;
            external_chip_select_n_o <= 1'b1;
        end else begin
            core_sel_o <= sel;
            emulation_chip_select_n_o <= !emu_cs_hit;
            external_chip_select_n_o <= !ext_cs_hit;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_bus_o <= '0;
        end else if (cpu_req_i.valid) begin
            core_bus_o.write <= cpu_req_i.write;
            core_bus_o.wide <= cpu_req_i.wide;
            core_bus_o.addr <= cpu_req_i.addr;
            core_bus_o.page <= page;
            // Byte writes ride on both lanes so either byte slot sees them
            core_bus_o.wdata <= cpu_req_i.wide ? cpu_req_i.wdata
                : {cpu_req_i.wdata[7:0], cpu_req_i.wdata[7:0]};
        end else begin
            core_bus_o.write <= 1'b0;
        end
    end

    logic [15:0] mux_rd;
    always_comb begin
        mux_rd = ({16{core_sel_o.debug}} & core_rdata_i.debug)
            | ({16{core_sel_o.regs}} & core_rdata_i.regs)
            | ({16{core_sel_o.ram}} & core_rdata_i.ram)
            | ({16{core_sel_o.eeprom}} & core_rdata_i.eeprom)
            | ({16{core_sel_o.flash}} & core_rdata_i.flash)
            | ({16{core_sel_o.ext}} & core_rdata_i.ext);
    end

    // Big-endian lanes: even byte on the high lane, returned low
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cpu_rdata_o <= 16'h0000;
        end else if (core_sel_o != '0 && !core_bus_o.write) begin
            if (core_bus_o.wide) begin
                cpu_rdata_o <= mux_rd;
            end else if (core_bus_o.addr[0]) begin
                cpu_rdata_o <= {8'h00, mux_rd[7:0]};
            end else begin
                cpu_rdata_o <= {8'h00, mux_rd[15:8]};
            end
        end
    end

    wire logic unused_ok = &{1'b0, hsize_i, haddr_i[31:10], haddr_i[1:0],
        hwdata_i[31:21], htrans_i[0]};
endmodule

`default_nettype wire

// ---- verification/cadp_core_sva.sv ----
// Assertion checker for the core address decode and paging block
`timescale 1ns/1ps
`default_nettype none
module cadp_core_sva (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic [1:0] flash_size_switch_i,
    input wire logic [1:0] paging_partition_switch_i,
    input wire logic background_debug_i,
    input wire cadp_pkg::cadp_req_t cpu_req_i,
    input wire cadp_pkg::cadp_rdata_t core_rdata_i,
    input wire logic [15:0] cpu_rdata_o,
    input wire cadp_pkg::cadp_bus_t core_bus_o,
    input wire cadp_pkg::cadp_sel_t core_sel_o,
    input wire logic emulation_chip_select_n_o,
    input wire logic external_chip_select_n_o,
    input wire logic far_wr_i,
    input wire logic [5:0] far_wdata_i,
    input wire logic [5:0] far_rdata_o
);
    import cadp_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic view_rd;
    assign view_rd = hsel_i && htrans_i[1] && hready_i && !hwrite_i
        && haddr_i[9:2] == CADP_IDX_VIEW;
    // ****************************************************
    // Assertions
    // ****************************************************
    sel_onehot_a: assert property ($onehot0(core_sel_o))
        else $error("more than one select");
    sel_idle_a: assert property (!cpu_req_i.valid |=> core_sel_o == '0)
        else $error("select without request");
    bus_addr_a: assert property (cpu_req_i.valid |=> core_bus_o.addr == $past(cpu_req_i.addr))
        else $error("address not steered");
    far_path_a: assert property (far_wr_i |=> far_rdata_o == $past(far_wdata_i))
        else $error("far page write lost");
    ext_cs_gate_a: assert property (!external_chip_select_n_o |->
        emulation_chip_select_n_o && core_sel_o.ext) else $error("external select misfired");
    emu_cs_flash_a: assert property (!emulation_chip_select_n_o |-> core_sel_o.flash)
        else $error("emulation select without flash");
    view_read_a: assert property (view_rd |=> hrdata_o == {24'h0,
        $past(flash_size_switch_i), 4'h0, $past(paging_partition_switch_i)})
        else $error("size view wrong");
    debug_top_a: assert property (cpu_req_i.valid && background_debug_i
        && cpu_req_i.addr[15:8] == 8'hFF |=> core_sel_o.debug) else $error("debug not first");
    rdata_wide_a: assert property (core_sel_o.regs && !core_bus_o.write && core_bus_o.wide
        && !core_bus_o.addr[0] |=> cpu_rdata_o == $past(core_rdata_i.regs))
        else $error("read data not muxed");
    cov_debug: cover property (core_sel_o.debug);
    cov_emu_cs: cover property (!emulation_chip_select_n_o);
    cov_ext_cs: cover property (!external_chip_select_n_o);
endmodule
bind cadp_core cadp_core_sva cadp_core_sva_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .flash_size_switch_i(flash_size_switch_i),
    .paging_partition_switch_i(paging_partition_switch_i),
    .background_debug_i(background_debug_i), .cpu_req_i(cpu_req_i),
    .core_rdata_i(core_rdata_i), .cpu_rdata_o(cpu_rdata_o), .core_bus_o(core_bus_o),
    .core_sel_o(core_sel_o), .emulation_chip_select_n_o(emulation_chip_select_n_o),
    .external_chip_select_n_o(external_chip_select_n_o), .far_wr_i(far_wr_i),
    .far_wdata_i(far_wdata_i), .far_rdata_o(far_rdata_o));
`default_nettype wire

// ---- verification/cadp_mem_model.sv ----
// Read bus model of the selected memories and register space
`timescale 1ns/1ps
`default_nettype none
module cadp_mem_model (
    input wire cadp_pkg::cadp_sel_t sel_i,
    input wire cadp_pkg::cadp_bus_t bus_i,
    output cadp_pkg::cadp_rdata_t rdata_o
);
    import cadp_pkg::*;
    // Unselected buses show the inverse, so a wrong lane never matches
    function automatic logic [15:0] pat(input logic [3:0] k, input logic s);
        pat = {k, 4'hA, bus_i.addr[7:0]} ^ {16{~s}};
    endfunction
    always_comb begin
        rdata_o.debug = pat(4'h1, sel_i.debug);
        rdata_o.regs = pat(4'h2, sel_i.regs);
        rdata_o.ram = pat(4'h3, sel_i.ram);
        rdata_o.eeprom = pat(4'h4, sel_i.eeprom);
        rdata_o.flash = pat(4'h5, sel_i.flash);
        rdata_o.ext = pat(4'h6, sel_i.ext);
    end
endmodule
`default_nettype wire

// ---- verification/cadp_core_bench.sv ----
// Self-checking bench for the core address decode and paging block
`timescale 1ns/1ps
`default_nettype none
module cadp_core_bench;
    import cadp_pkg::*;
    localparam logic [5:0] DBG = 6'h20, REG = 6'h10, RAM = 6'h08, EE = 6'h04;
    localparam logic [5:0] FL = 6'h02, EXT = 6'h01, NONE = 6'h00;
    logic clk_i, nrst_i, hwrite, far_wr, dbg, hrdy, hresp, emu_cs_n, ext_cs_n;
    logic [1:0] htrans, fsw, psw;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [5:0] far_wd, far_rd;
    logic [15:0] cpu_rd;
    cadp_mode_t mode;
    cadp_req_t req;
    cadp_rdata_t crd;
    cadp_bus_t cbus;
    cadp_sel_t csel;
    int fails, tests_run, cyc;
    cadp_core cadp_core_inst (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .flash_size_switch_i(fsw), .paging_partition_switch_i(psw), .mode_i(mode),
        .background_debug_i(dbg), .cpu_req_i(req), .core_rdata_i(crd), .cpu_rdata_o(cpu_rd),
        .core_bus_o(cbus), .core_sel_o(csel), .emulation_chip_select_n_o(emu_cs_n),
        .external_chip_select_n_o(ext_cs_n), .far_wr_i(far_wr), .far_wdata_i(far_wd),
        .far_rdata_o(far_rd));
    cadp_mem_model cadp_mem_model_inst (.sel_i(csel), .bus_i(cbus), .rdata_o(crd));
    // ****************************************************
    // Clock, timeout and report
    // ****************************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // ****************************************************
    // Bus tasks
    // ****************************************************
    task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        @(posedge clk_i);
        while (hrdy !== 1'b1) @(posedge clk_i);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_i);
        while (hrdy !== 1'b1) @(posedge clk_i);
        q = hrdata;
    endtask
    // One CPU access; checks select, chip selects and returned data
    task automatic dec(input cadp_mode_t m, input logic [15:0] a, input logic w,
                       input logic [5:0] es, input logic [1:0] ec);
        logic [15:0] p;
        p = 16'h0;
        for (int b = 0; b < 6; b++) if (es[b]) p = {4'(6 - b), 4'hA, a[7:0]};
        @(posedge clk_i);
        mode <= m;
        req <= '{1'b1, 1'b0, w, a, 16'h0};
        @(posedge clk_i);
        req.valid <= 1'b0;
        @(negedge clk_i);
        chk("select", 32'(es), 32'(csel));
        chk("chip selects", 32'(ec), {30'h0, emu_cs_n, ext_cs_n});
        @(negedge clk_i);
        if (es != NONE) chk("cpu read", w ? 32'(p) : 32'(a[0] ? p[7:0] : p[15:8]),
            w ? 32'(cpu_rd) : 32'(cpu_rd[7:0]));
    endtask
    task automatic set(input logic [7:0] idx, input logic [31:0] d);
        ahb(1'b1, idx, d);
    endtask
    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        {nrst_i, hwrite, far_wr, dbg, htrans, haddr, hwdata, far_wd} = '0;
        {fsw, psw, fails, tests_run, cyc} = '0;
        mode = CADP_MODE_NORM_SINGLE;
        req = '0;
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        ahb(1'b0, CADP_IDX_PAGE, 32'h0);
        chk("page reset", 32'h0, q);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            fsw <= 2'(i);
            psw <= 2'(3 - i);
            ahb(1'b0, CADP_IDX_VIEW, 32'h0);
            chk("size view", {24'h0, 2'(i), 4'h0, 2'(3 - i)}, q);
        end
        set(CADP_IDX_VIEW, 32'hFF);
        chk("view write okay", 32'h0, 32'(hresp));
        ahb(1'b0, CADP_IDX_VIEW, 32'h0);
        chk("view after write", 32'hC0, q);
        fsw <= 2'h1;
        psw <= 2'h0;
        set(8'h05, 32'h5A);
        ahb(1'b0, 8'h05, 32'h0);
        chk("unmapped", 32'h0, q);
        set(CADP_IDX_PAGE, 32'h25);
        @(negedge clk_i);
        chk("page next cycle", 32'h25, 32'(far_rd));
        ahb(1'b0, CADP_IDX_PAGE, 32'h0);
        chk("page read", 32'h25, q);
        @(posedge clk_i);
        far_wr <= 1'b1;
        far_wd <= 6'h3F;
        @(posedge clk_i);
        far_wr <= 1'b0;
        @(negedge clk_i);
        chk("far page", 32'h3F, 32'(far_rd));
        ahb(1'b0, CADP_IDX_PAGE, 32'h0);
        chk("far via bus", 32'h3F, q);
        // Window: partition 00 puts pages 0x38 and up on chip
        set(CADP_IDX_PAGE, 32'h38);
        dec(CADP_MODE_NORM_SINGLE, 16'h8000, 1'b1, FL, 2'b11);
        set(CADP_IDX_PAGE, 32'h37);
        dec(CADP_MODE_NORM_SINGLE, 16'hBFFE, 1'b1, NONE, 2'b11);
        dec(CADP_MODE_NORM_WIDE, 16'h8000, 1'b1, EXT, 2'b11);
        dec(CADP_MODE_NORM_SINGLE, 16'hC000, 1'b1, FL, 2'b11);
        dec(CADP_MODE_NORM_SINGLE, 16'h0000, 1'b1, REG, 2'b11);
        dec(CADP_MODE_NORM_SINGLE, 16'h0101, 1'b0, REG, 2'b11);
        dec(CADP_MODE_NORM_SINGLE, 16'h0100, 1'b0, REG, 2'b11);
        dec(CADP_MODE_NORM_WIDE, 16'h0000, 1'b1, EXT, 2'b11);
        dec(CADP_MODE_NORM_WIDE, 16'h0003, 1'b1, EXT, 2'b11);
        dec(CADP_MODE_NORM_WIDE, 16'h0008, 1'b1, REG, 2'b11);
        dec(CADP_MODE_NORM_WIDE, 16'h3010, 1'b1, RAM, 2'b11);
        dec(CADP_MODE_SPEC_PERIPH, 16'h000F, 1'b1, EXT, 2'b11);
        dec(CADP_MODE_SPEC_PERIPH, 16'h0010, 1'b1, REG, 2'b11);
        dec(CADP_MODE_EMUL_WIDE, 16'h0032, 1'b1, REG, 2'b11);
        @(posedge clk_i);
        dbg <= 1'b1;
        dec(CADP_MODE_NORM_SINGLE, 16'hFF10, 1'b1, DBG, 2'b11);
        @(posedge clk_i);
        dbg <= 1'b0;
        dec(CADP_MODE_NORM_SINGLE, 16'hFF10, 1'b1, FL, 2'b11);
        // Port E and port K moved out, chip selects live
        set(CADP_IDX_CTRL, 32'h19);
        dec(CADP_MODE_NORM_WIDE, 16'h0009, 1'b1, EXT, 2'b11);
        dec(CADP_MODE_EMUL_WIDE, 16'h0033, 1'b1, EXT, 2'b11);
        dec(CADP_MODE_EMUL_WIDE, 16'hC000, 1'b1, FL, 2'b01);
        dec(CADP_MODE_EMUL_WIDE, 16'h5000, 1'b1, EXT, 2'b10);
        // RAM moved under registers and over EEPROM
        set(CADP_IDX_CTRL, 32'h05);
        set(CADP_IDX_BASE, 32'h0001_0000);
        dec(CADP_MODE_NORM_SINGLE, 16'h0100, 1'b1, REG, 2'b11);
        dec(CADP_MODE_NORM_SINGLE, 16'h0500, 1'b1, RAM, 2'b11);
        dec(CADP_MODE_NORM_SINGLE, 16'h0900, 1'b1, RAM, 2'b11);
        set(CADP_IDX_BASE, 32'h0001_0300);
        dec(CADP_MODE_NORM_SINGLE, 16'h0900, 1'b1, EE, 2'b11);
        // Lower fixed flash hidden, window still reaches it
        @(posedge clk_i);
        fsw <= 2'h2;
        set(CADP_IDX_PAGE, 32'h38);
        dec(CADP_MODE_NORM_SINGLE, 16'h4000, 1'b1, FL, 2'b11);
        set(CADP_IDX_CTRL, 32'h03);
        dec(CADP_MODE_NORM_SINGLE, 16'h4000, 1'b1, NONE, 2'b11);
        dec(CADP_MODE_NORM_SINGLE, 16'h8000, 1'b1, FL, 2'b11);
        // Byte write rides both lanes; bus carries the live page
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, 1'b0, 16'h3001, 16'h00C5};
        @(posedge clk_i);
        req.valid <= 1'b0;
        @(negedge clk_i);
        chk("byte write lanes", 32'hC5C5, 32'(cbus.wdata));
        chk("bus page", 32'h38, 32'(cbus.page));
        end_sim();
    end
endmodule
`default_nettype wire
